// [hw/acc_pkg.sv]
// Package of constants and types for the comparator control and status block
// How it works
// - Power-off bit switches comparator power off.
// - Reference select picks bandgap, else positive pin.
// - Compare output synchronised, one to two cycles.
// - Matching output event sets the event flag.
// - Irq needs flag, local enable, global enable.
// - Vector execution clears the event flag.
// - Writing one clears flag; zero leaves it.
// - Capture route feeds output to timer capture.
// - Route off disconnects output from capture.
// - Mode field: toggle, reserved, falling, rising.
// - Raw output high when positive exceeds negative.
package acc_pkg;
  // Register byte offsets
  localparam logic [11:0] ACC_CTRL_OFS   = 12'h000;  // Control and status
  localparam logic [11:0] ACC_IRQST_OFS  = 12'h004;  // Sticky interrupt status
  localparam logic [11:0] ACC_IRQMSK_OFS = 12'h008;  // Interrupt mask
  localparam logic [11:0] ACC_SYS_OFS    = 12'h00c;  // Global enable and vector ack
  // Control field positions
  localparam int ACC_PWR_OFF_BIT = 7;
  localparam int ACC_REF_SEL_BIT = 6;
  localparam int ACC_OUT_BIT     = 5;
  localparam int ACC_FLAG_BIT    = 4;
  localparam int ACC_IRQ_EN_BIT  = 3;
  localparam int ACC_ROUTE_BIT   = 2;
  localparam int ACC_MODE_HI_BIT = 1;
  localparam int ACC_MODE_LO_BIT = 0;
  // System register field positions
  localparam int ACC_GIE_BIT     = 0;
  localparam int ACC_VEC_ACK_BIT = 1;
  // Status and mask field positions
  localparam int ACC_ST_EVENT_BIT = 0;
  localparam int ACC_ST_ERR_BIT   = 1;
  // Reset values
  localparam logic [7:0] ACC_CTRL_RST   = 8'h00;
  localparam logic [1:0] ACC_IRQMSK_RST = 2'h0;
  localparam logic       ACC_GIE_RST    = 1'b0;
  // Synchroniser depth
  localparam int ACC_SYNC_STAGES = 2;
  // Event mode codes
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE   = 2'b00,
    ACC_MODE_RESERVED = 2'b01,
    ACC_MODE_FALL     = 2'b10,
    ACC_MODE_RISE     = 2'b11
  } acc_mode_t;
  // Control register fields
  typedef struct packed {
    logic      power_off;
    logic      ref_select;
    logic      irq_enable;
    logic      route_en;
    acc_mode_t mode;
  } acc_ctrl_t;
  // Analog side outputs
  typedef struct packed {
    logic power_off;
    logic ref_select;
  } acc_analog_t;
endpackage

// [hw/acc_sync.sv]
// Two-flop synchroniser for the raw comparator output
`timescale 1ns/1ps
module acc_sync
  import acc_pkg::*;
#(
  parameter int STAGES = ACC_SYNC_STAGES
)(
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  // Fewer than two stages would let metastability through
  if (STAGES < 2)
  begin : g_bad_stages
    $error("acc_sync needs at least two stages");
  end

  logic [STAGES-1:0] chain;  // Stage 0 is read only by stage 1

  // Shift chain; the first flop feeds nothing but the next
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      chain <= '0;
    else
      chain <= {chain[STAGES-2:0], i_async};
  end

  assign o_sync = chain[STAGES-1];
endmodule

// [hw/acc_top.sv]
// Comparator control and status block with APB register access
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_raw_compare,
  output logic             o_power_off,
  output logic             o_ref_select,
  output logic             o_capture_in,
  output logic             o_cmp_irq_req,
  output logic             o_irq
);
  // Register state
  acc_ctrl_t   ctrl;        // Writable control fields
  logic        flag;        // Comparator event flag
  logic        gie;         // Global interrupt enable
  logic [1:0]  irq_status;  // Sticky block status
  logic [1:0]  irq_mask;    // Block interrupt mask
  logic        prev_out;    // Synced output one cycle back
  logic        synced_out;  // Synchroniser result

  // Raw output is made by the analog core; sync it before any use
  acc_sync #(
    .STAGES (ACC_SYNC_STAGES)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_async    (i_raw_compare),
    .o_sync     (synced_out)
  );

  // Bus decode
  // Access phase of a transfer; setup cycles need no decode here
  wire access     = i_psel && i_penable;
  wire hit_ctrl   = i_paddr == ACC_CTRL_OFS;
  wire hit_irqst  = i_paddr == ACC_IRQST_OFS;
  wire hit_irqmsk = i_paddr == ACC_IRQMSK_OFS;
  wire hit_sys    = i_paddr == ACC_SYS_OFS;
  wire mapped     = hit_ctrl || hit_irqst || hit_irqmsk || hit_sys;
  wire lane0      = i_pstrb[0];
  // Write and read strobes taken once, at the access edge with pready high
  wire wr_ctrl    = access && o_pready && i_pwrite && hit_ctrl && lane0;
  wire wr_msk     = access && o_pready && i_pwrite && hit_irqmsk && lane0;
  wire wr_sys     = access && o_pready && i_pwrite && hit_sys && lane0;
  wire rd_irqst   = access && o_pready && !i_pwrite && hit_irqst;

  // Event detection from synced value against previous cycle
  wire rise_ev    = synced_out && !prev_out;
  wire fall_ev    = !synced_out && prev_out;
  // Reserved code selects nothing
  wire match_ev   = (ctrl.mode == ACC_MODE_TOGGLE) ? (rise_ev || fall_ev) :
                    (ctrl.mode == ACC_MODE_FALL)   ? fall_ev :
                    (ctrl.mode == ACC_MODE_RISE)   ? rise_ev : 1'b0;
  // Flag clears: written one, or vector taken
  wire flag_w1c   = wr_ctrl && i_pwdata[ACC_FLAG_BIT];
  wire vec_ack    = wr_sys && i_pwdata[ACC_VEC_ACK_BIT];
  // Set wins over any clear in the same cycle
  wire next_flag  = match_ev || (flag && !flag_w1c && !vec_ack);
  // Power-off change while enabled is the documented hazard
  wire pwr_change = wr_ctrl && (i_pwdata[ACC_PWR_OFF_BIT] != ctrl.power_off) && ctrl.irq_enable;
  wire mode_chg   = wr_ctrl && (i_pwdata[ACC_MODE_HI_BIT:ACC_MODE_LO_BIT] != ctrl.mode) && ctrl.irq_enable;
  wire misuse     = pwr_change || mode_chg;
  // Status sets win over clear-on-read
  wire [1:0] st_set      = {misuse, match_ev};
  wire [1:0] next_status = st_set | (rd_irqst ? 2'h0 : irq_status);
  // Next enables, so the request flop tracks the registers without lag
  wire next_ctrl_irq_en = wr_ctrl ? i_pwdata[ACC_IRQ_EN_BIT] : ctrl.irq_enable;
  wire next_gie   = wr_sys ? i_pwdata[ACC_GIE_BIT] : gie;
  // Request needs flag, local enable and global enable together
  wire next_req   = next_flag && next_ctrl_irq_en && next_gie;
  // Read data mux
  wire [7:0] ctrl_rd = {ctrl.power_off, ctrl.ref_select, synced_out, flag,
                        ctrl.irq_enable, ctrl.route_en, ctrl.mode};
  wire [31:0] rd_mux = hit_ctrl   ? {24'h000000, ctrl_rd} :
                       hit_irqst  ? {30'h00000000, irq_status} :
                       hit_irqmsk ? {30'h00000000, irq_mask} :
                       hit_sys    ? {31'h00000000, gie} : 32'h00000000;

  // Control fields; power-off may be written at any time
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      ctrl <= acc_ctrl_t'({ACC_CTRL_RST[7:6], ACC_CTRL_RST[3:0]});
    else if (wr_ctrl)
      ctrl <= acc_ctrl_t'({i_pwdata[7:6], i_pwdata[3:0]});
  end

  // Event flag with hardware set priority
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end

  // Previous synced value for edge compare
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      prev_out <= 1'b0;
    else
      prev_out <= synced_out;
  end

  // Global enable, mask and sticky status
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      gie        <= ACC_GIE_RST;
      irq_mask   <= ACC_IRQMSK_RST;
      irq_status <= 2'h0;
    end
    else
    begin
      gie        <= next_gie;
      irq_status <= next_status;
      if (wr_msk)
        irq_mask <= i_pwdata[1:0];
    end
  end

  // Analog controls straight from flops; follow a write in the same edge
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_power_off   <= 1'b0;
      o_ref_select  <= 1'b0;
    end
    else
    begin
      o_power_off   <= wr_ctrl ? i_pwdata[ACC_PWR_OFF_BIT] : ctrl.power_off;
      o_ref_select  <= wr_ctrl ? i_pwdata[ACC_REF_SEL_BIT] : ctrl.ref_select;
    end
  end

  // Capture path; route gated here so a cleared route holds the input low
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_capture_in  <= 1'b0;
    else
      o_capture_in  <= ctrl.route_en && synced_out;
  end

  // Interrupt outputs; a one-cycle lag would let a cleared flag request once more
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_cmp_irq_req <= 1'b0;
      o_irq         <= 1'b0;
    end
    else
    begin
      o_cmp_irq_req <= next_req;
      o_irq         <= |(next_status & irq_mask);
    end
  end

  // APB: pready rises one cycle into the access phase
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_pready   <= 1'b0;
      o_pslverr  <= 1'b0;
      o_prdata   <= 32'h00000000;
    end
    else
    begin
      // Exactly one wait state; the pulse drops once the master has seen it
      o_pready   <= access && !o_pready;
      o_pslverr  <= access && !o_pready && !mapped;
      o_prdata   <= (access && !o_pready && !i_pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Checks beside the logic they guard
  a_flag_on_rise: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ctrl.mode == ACC_MODE_RISE && rise_ev) |=> flag)
    else $error("flag not set on rising event");
  a_reserved_quiet: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ctrl.mode == ACC_MODE_RESERVED && !flag && !$past(flag)) |=> !flag || $past(ctrl.mode) != ACC_MODE_RESERVED)
    else $error("flag set in reserved mode");
  a_irq_req_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_cmp_irq_req |-> (flag && ctrl.irq_enable && gie))
    else $error("request without flag and enables");
  a_flag_w1c: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (flag_w1c && !match_ev) |=> !flag)
    else $error("write one did not clear flag");
  a_vector_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (vec_ack && !match_ev) |=> !flag)
    else $error("vector did not clear flag");
  a_power_follow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_ctrl |=> o_power_off == $past(i_pwdata[ACC_PWR_OFF_BIT]))
    else $error("power off does not follow write");
  a_route_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !ctrl.route_en |=> !o_capture_in)
    else $error("capture driven while route off");
  a_sync_delay: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(i_raw_compare) ##1 i_raw_compare[*2] |-> synced_out)
    else $error("synced output late");
  a_ref_follow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    wr_ctrl |=> o_ref_select == $past(i_pwdata[ACC_REF_SEL_BIT]))
    else $error("reference select does not follow write");

  // Falling mode must catch a falling synced edge
  a_flag_on_fall: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ctrl.mode == ACC_MODE_FALL && fall_ev) |=> flag)
    else $error("flag not set on falling event");

  // Toggle mode must catch either edge
  a_flag_on_toggle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (ctrl.mode == ACC_MODE_TOGGLE && (rise_ev || fall_ev)) |=> flag)
    else $error("flag not set on toggle event");

  // Request must rise as soon as all three conditions hold
  a_irq_req_set: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (flag && ctrl.irq_enable && gie) |-> o_cmp_irq_req)
    else $error("request missing with flag and enables");

  // Power-off level holds its register value between writes
  a_power_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !wr_ctrl |=> o_power_off == $past(ctrl.power_off))
    else $error("power off moved without a write");

  // Routed capture input follows the synced output one cycle later
  a_capture_follow: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ctrl.route_en |=> o_capture_in == $past(synced_out))
    else $error("capture input does not follow output");

  // Mode change with the interrupt enabled is logged as misuse
  a_misuse_logged: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    misuse |=> irq_status[ACC_ST_ERR_BIT])
    else $error("misuse not recorded in status");

  // Event status bit stays until read
  a_status_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (irq_status[ACC_ST_EVENT_BIT] && !rd_irqst) |=> irq_status[ACC_ST_EVENT_BIT])
    else $error("event status lost without a read");

  // Ready is a single-cycle pulse
  a_pready_pulse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");

  // Read data is zero outside the answer cycle
  a_prdata_idle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !o_pready |-> o_prdata == 32'h00000000)
    else $error("read data present without pready");

  // Error response only alongside ready
  a_slverr_ready: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_pslverr |-> o_pready)
    else $error("slave error without pready");

  // Unmasked pending status raises the interrupt line
  a_irq_line: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (irq_status[ACC_ST_EVENT_BIT] && irq_mask[ACC_ST_EVENT_BIT] && $stable(irq_mask)) |-> o_irq)
    else $error("interrupt line low with unmasked status");
endmodule

// [sim/acc_cmp_model.sv]
// Behavioural analog comparator core on the far side of the block
`timescale 1ns/1ps
module acc_cmp_model (
  input  wire logic i_power_off,
  input  wire logic i_ref_select,
  input  int        i_pos_mv,
  input  int        i_neg_mv,
  input  int        i_gap_mv,
  output logic      o_raw
);
  // Positive input: bandgap or pin
  int pos_sel;  // Chosen positive level
  assign pos_sel = i_ref_select ? i_gap_mv : i_pos_mv;
  // Unpowered core reads low; a real one floats
  assign o_raw = !i_power_off && (pos_sel > i_neg_mv);
endmodule

// [sim/testbench.sv]
// Self-checking testbench for the comparator control block
`timescale 1ns/1ps
module testbench;
  import acc_pkg::*;
  logic        clk = 1'b0;   // Core clock
  logic        rst = 1'b1;   // Sync reset
  logic        psel = 1'b0;  // APB select
  logic        pen = 1'b0;   // APB enable
  logic        pwr = 1'b0;   // APB write
  logic [11:0] padr = '0;    // APB address
  logic [31:0] pwd = '0;     // APB write data
  logic [31:0] prd;          // APB read data
  logic        prdy;         // APB ready
  logic        perr;         // APB error
  logic        raw;          // Comparator output
  logic        pwr_off;      // Power-off level
  logic        ref_sel;      // Reference select
  logic        cap;          // Capture input
  logic        req;          // Comparator irq request
  logic        irq;          // Status irq
  int          pos = 300;    // Positive pin level
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        er;
  logic [4:0]  r;
  // Rows: mode, start level, end level, flag expected
  logic [4:0] rows [8] = '{5'b00011, 5'b00101, 5'b10010, 5'b10101,
                           5'b11011, 5'b11100, 5'b01010, 5'b01100};
  logic [11:0] adr [3] = '{ACC_CTRL_OFS, ACC_IRQMSK_OFS, ACC_SYS_OFS};

  // Clock, 40 ns period
  always #20 clk = ~clk;

  acc_top acc_top_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .i_pstrb(4'hf), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr), .i_raw_compare(raw), .o_power_off(pwr_off),
    .o_ref_select(ref_sel), .o_capture_in(cap), .o_cmp_irq_req(req), .o_irq(irq));
  acc_cmp_model acc_cmp_model_inst (.i_power_off(pwr_off), .i_ref_select(ref_sel),
    .i_pos_mv(pos), .i_neg_mv(500), .i_gap_mv(600), .o_raw(raw));

  // Verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Let n edges pass, then settle at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Move the positive pin across the threshold
  task automatic lvl(input logic v);
    @(posedge clk);
    pos <= v ? 700 : 300;
    cyc(6);
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (adr[k])
    begin
      apb(1'b0, adr[k], 32'h0, rd, er);
      chk("reset value", rd, 32'h0);
    end
    // Event modes; irq enable stays off while mode changes
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      apb(1'b1, ACC_CTRL_OFS, {30'h0, r[4:3]}, rd, er);
      lvl(r[2]);
      apb(1'b1, ACC_CTRL_OFS, {27'h0, 1'b1, 2'h0, r[4:3]}, rd, er);
      lvl(r[1]);
      apb(1'b0, ACC_CTRL_OFS, 32'h0, rd, er);
      chk("flag", rd[4], r[0]);
      chk("synced out", rd[5], r[1]);
      apb(1'b1, ACC_CTRL_OFS, {30'h0, r[4:3]}, rd, er);
      apb(1'b0, ACC_CTRL_OFS, 32'h0, rd, er);
      chk("flag kept", rd[4], r[0]);
    end
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk("slverr", er, 1'b1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, ACC_CTRL_OFS, 32'hc0, rd, er);
    cyc(1);
    chk("power off", pwr_off, 1'b1);
    chk("ref select", ref_sel, 1'b1);
    apb(1'b1, ACC_CTRL_OFS, 32'h40, rd, er);
    cyc(6);
    apb(1'b0, ACC_CTRL_OFS, 32'h0, rd, er);
    chk("bandgap out", rd[5], 1'b1);
    apb(1'b1, ACC_CTRL_OFS, 32'h44, rd, er);
    cyc(4);
    chk("capture on", cap, 1'b1);
    apb(1'b1, ACC_CTRL_OFS, 32'h43, rd, er);
    cyc(2);
    chk("capture off", cap, 1'b0);
    // Interrupt path: rising mode, enable, global enable, mask
    lvl(1'b0);
    apb(1'b1, ACC_IRQMSK_OFS, 32'h1, rd, er);
    apb(1'b1, ACC_SYS_OFS, 32'h1, rd, er);
    apb(1'b0, ACC_IRQST_OFS, 32'h0, rd, er);
    apb(1'b1, ACC_CTRL_OFS, 32'h1b, rd, er);
    lvl(1'b1);
    chk("irq req", req, 1'b1);
    chk("irq", irq, 1'b1);
    apb(1'b0, ACC_IRQST_OFS, 32'h0, rd, er);
    chk("status", rd[0], 1'b1);
    apb(1'b0, ACC_IRQST_OFS, 32'h0, rd, er);
    chk("status cleared", rd[0], 1'b0);
    chk("irq low", irq, 1'b0);
    apb(1'b1, ACC_CTRL_OFS, 32'h03, rd, er);
    cyc(1);
    chk("req masked", req, 1'b0);
    apb(1'b1, ACC_CTRL_OFS, 32'h0b, rd, er);
    cyc(1);
    chk("req again", req, 1'b1);
    apb(1'b1, ACC_SYS_OFS, 32'h3, rd, er);
    apb(1'b0, ACC_CTRL_OFS, 32'h0, rd, er);
    chk("vector clear", rd[4], 1'b0);
    chk("req gone", req, 1'b0);
    // Mid-run reset: outputs clear, system register back to reset value
    @(posedge clk);
    rst <= 1'b1;
    cyc(3);
    chk("reset power", pwr_off, 1'b0);
    chk("reset req", req, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ACC_SYS_OFS, 32'h0, rd, er);
    chk("reset sys", rd, 32'h0);
    print_verdict();
  end
endmodule
